// ===== logic/fcd_pkg.sv
// Constants, command codes and state encoding for the flash command decoder.
// Assumes a 250 MHz system clock and a 16-bit host memory bus.
package fcd_pkg;
	localparam int CLK_MHZ = 250;
	localparam int WIN_US = 80;
	localparam int WIN_CYCLES = WIN_US * CLK_MHZ;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int PRI_N = 16;
	localparam int SEC_N = 4;
	localparam int SECT_N = PRI_N + SEC_N;
	localparam int TMO_W = 16;
	localparam logic [11:0] ADR_UNLOCK1 = 12'haaa;
	localparam logic [11:0] ADR_UNLOCK2 = 12'h554;
	localparam logic [7:0] ADR_ID = 8'h02;
	localparam logic [7:0] ADR_PROT = 8'h04;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_BULK = 8'h10;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_BYPEXIT = 8'h00;
	// Identifier value is arbitrary.
	localparam logic [7:0] ID_CODE = 8'h5c;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERR_BIT = 5;
	localparam int WINDOW_BIT = 3;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_TIMEOUT = 4'h4;
	typedef enum logic [3:0] {
		ST_READ = 4'h0,
		ST_UNL1 = 4'h1,
		ST_UNL2 = 4'h3,
		ST_PGM = 4'h2,
		ST_ESECT = 4'h6,
		ST_IDMODE = 4'h7,
		ST_BYP = 4'h5,
		ST_BYPPGM = 4'h4,
		ST_BYPEXIT = 4'hc
	} fcd_state_e;
endpackage

// ===== logic/fcd_flash_command_decoder.sv
// Command decoder and read-mode control for a dual-bank embedded flash.
// Assumes host bus pins synchronous to clk and an external embedded algorithm engine.
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module fcd_flash_command_decoder #(
	parameter int TIMEOUT_CYCLES = fcd_pkg::WIN_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [fcd_pkg::ADDR_W-1:0] hostAddr,
	input wire logic [fcd_pkg::DATA_W-1:0] hostWrData,
	input wire logic writeStrobeLow_n,
	input wire logic hostRead,
	input wire logic [fcd_pkg::PRI_N-1:0] primarySectorSelects,
	input wire logic [fcd_pkg::SEC_N-1:0] secondarySectorSelects,
	input wire logic writeLockoutVoltage,
	output logic [fcd_pkg::DATA_W-1:0] hostRdData,
	input wire logic [fcd_pkg::DATA_W-1:0] arrayRdData,
	input wire logic [fcd_pkg::SECT_N-1:0] sectorProtect,
	input wire logic algBusy,
	input wire logic algFail,
	output logic programStart,
	output logic [fcd_pkg::ADDR_W-1:0] programAddress,
	output logic [fcd_pkg::DATA_W-1:0] programDataWord,
	output logic [fcd_pkg::SECT_N-1:0] eraseSectorMask,
	output logic eraseStart,
	output logic eraseBulk,
	output logic eraseSuspend,
	output logic eraseResume,
	output logic busyStatusPin,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import fcd_pkg::*;

	fcd_state_e state_reg, state_next;
	logic wrPrev_reg, blocked_reg, latPri_reg, latSec_reg, armed_reg;
	logic [ADDR_W-1:0] latAddr_reg;
	logic [SECT_N-1:0] latSel_reg;
	logic [TMO_W-1:0] tmoLen_reg, tmoCnt_reg;
	logic erasing_reg, suspended_reg, error_reg, toggle_reg, algPrev_reg, ack_reg;
	logic [DATA_W-1:0] rdData_next;

	// Strobe edges and command write qualification.
	wire wrFall = wrPrev_reg & ~writeStrobeLow_n;
	wire wrRise = ~wrPrev_reg & writeStrobeLow_n;
	wire cmdWrite = wrRise & ~blocked_reg & (latPri_reg | latSec_reg);
	wire [7:0] cmdByte = hostWrData[7:0];
	wire [11:0] cmdAdr = latAddr_reg[11:0];
	wire evenAdr = ~latAddr_reg[0];
	wire isUnl1 = cmdByte == CMD_UNLOCK1 && cmdAdr == ADR_UNLOCK1;
	wire isUnl2 = cmdByte == CMD_UNLOCK2 && cmdAdr == ADR_UNLOCK2;
	wire atUnl1 = cmdAdr == ADR_UNLOCK1;
	wire timing = state_reg == ST_UNL1 || state_reg == ST_UNL2 || state_reg == ST_PGM || state_reg == ST_ESECT
		|| (state_reg == ST_READ && armed_reg);
	wire tmoExpire = timing && tmoCnt_reg == '0 && !cmdWrite;
	wire hitsErase = |(latSel_reg & eraseSectorMask);
	wire pgmOk = !(|(latSel_reg & sectorProtect)) && !(suspended_reg && hitsErase);
	wire doSuspend = cmdWrite && state_reg == ST_READ && evenAdr && cmdByte == CMD_SUSPEND && erasing_reg
		&& !suspended_reg;
	wire doResume = cmdWrite && state_reg == ST_READ && evenAdr && cmdByte == CMD_SECTOR && suspended_reg;
	wire doProgram = cmdWrite && (state_reg == ST_PGM || state_reg == ST_BYPPGM) && evenAdr && pgmOk;
	wire doBulk = cmdWrite && state_reg == ST_UNL2 && armed_reg && atUnl1 && cmdByte == CMD_BULK;
	wire closeWin = state_reg == ST_ESECT && tmoExpire;
	wire doReset = cmdWrite && evenAdr && cmdByte == CMD_RESET;
	wire curPri = |primarySectorSelects;
	wire curSec = |secondarySectorSelects;
	wire [SECT_N-1:0] curSel = {secondarySectorSelects, primarySectorSelects};
	wire statusRead = (algBusy || erasing_reg) && !suspended_reg && (curPri || curSec);
	wire avsReg = avs_address == REG_STATUS || avs_address == REG_TIMEOUT;
	wire [31:0] avsRd = avs_address == REG_STATUS
		? {24'h0, state_reg, suspended_reg, erasing_reg, error_reg, busyStatusPin}
		: (avs_address == REG_TIMEOUT ? {16'h0, tmoLen_reg} : 32'h0);

	// Command sequencer.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_READ: begin
				if (cmdWrite && isUnl1)
					state_next = ST_UNL1;
			end
			ST_UNL1: begin
				if (tmoExpire)
					state_next = ST_READ;
				else if (cmdWrite)
					state_next = isUnl2 ? ST_UNL2 : ST_READ;
			end
			ST_UNL2: begin
				if (tmoExpire)
					state_next = ST_READ;
				else if (cmdWrite && armed_reg)
					state_next = cmdByte == CMD_SECTOR ? ST_ESECT : ST_READ;
				else if (cmdWrite && atUnl1) begin
					case (cmdByte)
						CMD_PROGRAM: state_next = ST_PGM;
						CMD_ERASE: state_next = ST_READ;
						CMD_AUTOSEL: state_next = ST_IDMODE;
						CMD_BYPASS: state_next = ST_BYP;
						default: state_next = ST_READ;
					endcase
				end else if (cmdWrite)
					state_next = ST_READ;
			end
			ST_PGM: begin
				if (tmoExpire || cmdWrite)
					state_next = ST_READ;
			end
			ST_ESECT: begin
				if (tmoExpire)
					state_next = ST_READ;
				else if (cmdWrite && cmdByte != CMD_SECTOR)
					state_next = ST_READ;
			end
			ST_IDMODE: begin
				if (doReset)
					state_next = ST_READ;
			end
			ST_BYP: begin
				if (cmdWrite && evenAdr && cmdByte == CMD_PROGRAM)
					state_next = ST_BYPPGM;
				else if (cmdWrite && evenAdr && cmdByte == CMD_AUTOSEL)
					state_next = ST_BYPEXIT;
			end
			ST_BYPPGM: begin
				if (cmdWrite)
					state_next = ST_BYP;
			end
			ST_BYPEXIT: begin
				if (cmdWrite)
					state_next = (evenAdr && cmdByte == CMD_BYPEXIT) ? ST_READ : ST_BYP;
			end
			default: state_next = ST_READ;
		endcase
	end

	// Read data path: array data, status word, identifier or protection byte.
	always_comb begin
		rdData_next = arrayRdData;
		if (state_reg == ST_IDMODE && hostAddr[7:0] == ADR_ID)
			rdData_next = curPri ? {8'h0, ID_CODE} : '0;
		else if (state_reg == ST_IDMODE && hostAddr[7:0] == ADR_PROT)
			rdData_next = {{(DATA_W-1){1'b0}}, |(curSel & sectorProtect)};
		else if (statusRead) begin
			rdData_next = '0;
			rdData_next[POLL_BIT] = erasing_reg ? 1'b0 : ~programDataWord[POLL_BIT];
			rdData_next[TOGGLE_BIT] = toggle_reg;
			rdData_next[ERR_BIT] = error_reg;
			rdData_next[WINDOW_BIT] = state_reg != ST_ESECT;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_READ;
			wrPrev_reg <= 1'b1;
			blocked_reg <= 1'b0;
			latAddr_reg <= '0;
			latPri_reg <= 1'b0;
			latSec_reg <= 1'b0;
			latSel_reg <= '0;
		end else begin
			state_reg <= state_next;
			wrPrev_reg <= writeStrobeLow_n;
			if (wrFall) begin
				blocked_reg <= writeLockoutVoltage;
				latAddr_reg <= hostAddr;
				latPri_reg <= curPri;
				latSec_reg <= curSec && !curPri;
				latSel_reg <= curSel;
			end
		end
	end

	// Time-out counter and sector-erase arming.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmoCnt_reg <= '0;
			armed_reg <= 1'b0;
		end else begin
			if (cmdWrite)
				tmoCnt_reg <= tmoLen_reg;
			else if (tmoCnt_reg != '0)
				tmoCnt_reg <= tmoCnt_reg - 1'b1;
			if (cmdWrite && state_reg == ST_UNL2 && atUnl1 && cmdByte == CMD_ERASE && !armed_reg)
				armed_reg <= 1'b1;
			else if (tmoExpire || (cmdWrite && state_next != ST_UNL1 && state_next != ST_UNL2))
				armed_reg <= 1'b0;
		end
	end

	// Requests to the embedded algorithm engine.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			programStart <= 1'b0;
			programAddress <= '0;
			programDataWord <= '0;
			eraseStart <= 1'b0;
			eraseBulk <= 1'b0;
			eraseSuspend <= 1'b0;
			eraseResume <= 1'b0;
			eraseSectorMask <= '0;
		end else begin
			programStart <= doProgram;
			if (doProgram) begin
				programAddress <= latAddr_reg;
				programDataWord <= hostWrData;
			end
			eraseStart <= closeWin || doBulk;
			eraseBulk <= doBulk;
			eraseSuspend <= doSuspend;
			eraseResume <= doResume;
			if (cmdWrite && state_next == ST_ESECT && state_reg == ST_UNL2)
				eraseSectorMask <= latSel_reg & ~sectorProtect;
			else if (cmdWrite && state_reg == ST_ESECT && cmdByte == CMD_SECTOR)
				eraseSectorMask <= eraseSectorMask | (latSel_reg & ~sectorProtect);
			else if (doBulk)
				eraseSectorMask <= ~sectorProtect;
		end
	end

	// Operation status flags and host read data.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			erasing_reg <= 1'b0;
			suspended_reg <= 1'b0;
			error_reg <= 1'b0;
			toggle_reg <= 1'b0;
			algPrev_reg <= 1'b0;
			busyStatusPin <= 1'b1;
			hostRdData <= '0;
		end else begin
			algPrev_reg <= algBusy;
			busyStatusPin <= ~algBusy;
			hostRdData <= rdData_next;
			if (hostRead && statusRead)
				toggle_reg <= ~toggle_reg;
			if (eraseStart)
				erasing_reg <= 1'b1;
			else if (algPrev_reg && !algBusy && !suspended_reg)
				erasing_reg <= 1'b0;
			if (doSuspend)
				suspended_reg <= 1'b1;
			else if (doResume)
				suspended_reg <= 1'b0;
			if (algFail)
				error_reg <= 1'b1;
			else if (doReset)
				error_reg <= 1'b0;
		end
	end

	// Avalon-MM slave: one wait cycle, then the answer.
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			avs_readdata <= '0;
			tmoLen_reg <= TMO_W'(TIMEOUT_CYCLES);
		end else begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
			if (avs_read)
				avs_readdata <= avsReg ? avsRd : 32'h0;
			if (avs_write && !avs_waitrequest && avs_address == REG_TIMEOUT)
				tmoLen_reg <= avs_writedata[TMO_W-1:0];
		end
	end

	property p_readMode;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_READ && !algBusy && !erasing_reg) |=> hostRdData == $past(arrayRdData);
	endproperty
	a_readMode: assert property (p_readMode) else $error("Read mode data mismatch.");

	property p_unlock2;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_UNL1 && cmdWrite && !isUnl2) |=> state_reg == ST_READ;
	endproperty
	a_unlock2: assert property (p_unlock2) else $error("Bad second coded byte not aborted.");

	property p_upperIgnored;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_READ && cmdWrite && cmdByte == CMD_UNLOCK1 && latAddr_reg[11:0] == ADR_UNLOCK1)
			|=> state_reg == ST_UNL1;
	endproperty
	a_upperIgnored: assert property (p_upperIgnored) else $error("First coded write not taken.");

	property p_program;
		@(posedge clk) disable iff (!rst_n)
		programStart |-> $past(state_reg) == ST_PGM || $past(state_reg) == ST_BYPPGM;
	endproperty
	a_program: assert property (p_program) else $error("Program started outside a sequence.");

	property p_sectorErase;
		@(posedge clk) disable iff (!rst_n)
		(eraseStart && !eraseBulk) |-> $past(state_reg) == ST_ESECT && $past(tmoCnt_reg) == '0;
	endproperty
	a_sectorErase: assert property (p_sectorErase) else $error("Sector erase before window end.");

	property p_suspend;
		@(posedge clk) disable iff (!rst_n)
		eraseSuspend |=> suspended_reg && erasing_reg;
	endproperty
	a_suspend: assert property (p_suspend) else $error("Suspend outside erase.");

	property p_resume;
		@(posedge clk) disable iff (!rst_n)
		eraseResume |-> $past(suspended_reg) ##1 !suspended_reg;
	endproperty
	a_resume: assert property (p_resume) else $error("Resume without suspend.");

	property p_reset;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_IDMODE && doReset) |=> state_reg == ST_READ && !error_reg || $past(algFail);
	endproperty
	a_reset: assert property (p_reset) else $error("Reset command not obeyed.");

	property p_bypassExit;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_BYPEXIT && cmdWrite && evenAdr && cmdByte == CMD_BYPEXIT) |=> state_reg == ST_READ;
	endproperty
	a_bypassExit: assert property (p_bypassExit) else $error("Bypass exit failed.");

	property p_timeout;
		@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_UNL1 && tmoExpire) |=> state_reg == ST_READ;
	endproperty
	a_timeout: assert property (p_timeout) else $error("Time-out did not abort.");

	property p_lockout;
		@(posedge clk) disable iff (!rst_n)
		(wrFall && writeLockoutVoltage) |=> blocked_reg && !cmdWrite;
	endproperty
	a_lockout: assert property (p_lockout) else $error("Write under lockout not blocked.");

	property p_busy;
		@(posedge clk) disable iff (!rst_n)
		algBusy |=> !busyStatusPin;
	endproperty
	a_busy: assert property (p_busy) else $error("Busy pin high during operation.");

	c_program: cover property (@(posedge clk) disable iff (!rst_n) programStart);
	c_bulk: cover property (@(posedge clk) disable iff (!rst_n) eraseStart && eraseBulk);
	c_suspend: cover property (@(posedge clk) disable iff (!rst_n) eraseSuspend);
	c_bypass: cover property (@(posedge clk) disable iff (!rst_n) state_reg == ST_BYPPGM);
endmodule
`default_nettype wire

// ===== bench/fcd_host_model.sv
// Host side of the flash bus: byte command writes, word program writes and reads.
// Assumes one task call at a time; a select argument packs {secondary, primary}.
`timescale 1ns/1ns
`default_nettype none
module fcd_host_model (
	input wire logic clk,
	input wire logic [fcd_pkg::DATA_W-1:0] hostRdData,
	output logic [fcd_pkg::ADDR_W-1:0] hostAddr,
	output logic [fcd_pkg::DATA_W-1:0] hostWrData,
	output logic writeStrobeLow_n,
	output logic hostRead,
	output logic [fcd_pkg::PRI_N-1:0] primarySectorSelects,
	output logic [fcd_pkg::SEC_N-1:0] secondarySectorSelects
);
	import fcd_pkg::*;
	initial begin
		hostAddr = '0;
		hostWrData = '0;
		writeStrobeLow_n = 1'b1;
		hostRead = 1'b0;
		primarySectorSelects = '0;
		secondarySectorSelects = '0;
	end
	// Address stands only at the strobe fall and data only at its rise; released lines show inverted values.
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [19:0] s);
		@(posedge clk);
		hostAddr <= a;
		hostWrData <= ~d;
		{secondarySectorSelects, primarySectorSelects} <= s;
		writeStrobeLow_n <= 1'b0;
		@(posedge clk);
		hostAddr <= ~a;
		hostWrData <= d;
		writeStrobeLow_n <= 1'b1;
		@(posedge clk);
		hostWrData <= ~d;
		{secondarySectorSelects, primarySectorSelects} <= '0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [19:0] s, output logic [15:0] d);
		@(posedge clk);
		hostAddr <= a;
		{secondarySectorSelects, primarySectorSelects} <= s;
		hostRead <= 1'b1;
		@(posedge clk);
		hostRead <= 1'b0;
		@(negedge clk);
		d = hostRdData;
		@(posedge clk);
		hostAddr <= ~a;
		{secondarySectorSelects, primarySectorSelects} <= '0;
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_flash_command_decoder.sv
// Self-checking testbench for the flash command decoder.
// Assumes fcd_pkg, the decoder and fcd_host_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_flash_command_decoder;
	import fcd_pkg::*;
	localparam int TMO = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic writeStrobeLow_n, hostRead, programStart, eraseStart, eraseBulk, eraseSuspend, eraseResume, busyStatusPin;
	logic [15:0] hostAddr, hostWrData, hostRdData, arrayRdData, programAddress, programDataWord, primarySectorSelects;
	logic [3:0] secondarySectorSelects;
	logic [19:0] eraseSectorMask;
	logic [19:0] sectorProtect = 20'h00008;
	logic writeLockoutVoltage = 1'b0;
	logic algBusy = 1'b0;
	logic algFail = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	int miscompares = 0;
	int comparisons = 0;
	int progCnt = 0;
	int eraseCnt = 0;
	int bulkCnt = 0;
	int suspCnt = 0;
	int resCnt = 0;
	assign arrayRdData = hostAddr ^ 16'h5a5a;
	fcd_flash_command_decoder #(.TIMEOUT_CYCLES(TMO)) uut (
		.clk, .rst_n, .hostAddr, .hostWrData, .writeStrobeLow_n, .hostRead, .primarySectorSelects,
		.secondarySectorSelects, .writeLockoutVoltage, .hostRdData, .arrayRdData, .sectorProtect, .algBusy,
		.algFail, .programStart, .programAddress, .programDataWord, .eraseSectorMask, .eraseStart, .eraseBulk,
		.eraseSuspend, .eraseResume, .busyStatusPin, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest
	);
	fcd_host_model host (
		.clk, .hostRdData, .hostAddr, .hostWrData, .writeStrobeLow_n, .hostRead, .primarySectorSelects,
		.secondarySectorSelects
	);
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (programStart === 1'b1) progCnt++;
		if (eraseStart === 1'b1) eraseCnt++;
		if (eraseBulk === 1'b1) bulkCnt++;
		if (eraseSuspend === 1'b1) suspCnt++;
		if (eraseResume === 1'b1) resCnt++;
	end
	task automatic report_and_stop();
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rdat);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic cw(input logic [15:0] a, input logic [7:0] b, input logic [19:0] s);
		host.wr(a, {8'h00, b}, s);
	endtask
	task automatic unl(input logic [19:0] s);
		cw({4'h5, ADR_UNLOCK1}, CMD_UNLOCK1, s);
		cw({4'ha, ADR_UNLOCK2}, CMD_UNLOCK2, s);
	endtask
	task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic [19:0] s);
		unl(s);
		cw({4'h0, ADR_UNLOCK1}, CMD_PROGRAM, s);
		host.wr(a, d, s);
		repeat (3) @(posedge clk);
	endtask
	task automatic erase6(input logic [7:0] b, input logic [15:0] a, input logic [19:0] s);
		unl(s);
		cw({4'h0, ADR_UNLOCK1}, CMD_ERASE, s);
		unl(s);
		cw(a, b, s);
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic [15:0] d;
		check(busyStatusPin === 1'b1, "busy pin at reset");
		host.rd(16'h1234, 20'h1, d);
		check(d === 16'h486e, "array read");
		bus(1'b0, REG_STATUS, 32'h0, r);
		check(r === 32'h1, "status at reset");
		bus(1'b0, REG_TIMEOUT, 32'h0, r);
		check(r === 32'(TMO), "timeout at reset");
		bus(1'b1, REG_TIMEOUT, 32'h0000abcd, r);
		bus(1'b0, REG_TIMEOUT, 32'h0, r);
		check(r === 32'h0000abcd, "timeout write");
		bus(1'b1, REG_TIMEOUT, 32'(TMO), r);
		bus(1'b0, 4'h8, 32'h0, r);
		check(r === 32'h0, "unmapped read");
	endtask
	task automatic t_program();
		logic [15:0] d;
		logic t;
		int n;
		n = progCnt;
		prog(16'h0246, 16'hc35a, 20'h1);
		check(progCnt == n + 1 && programAddress === 16'h0246, "program start");
		check(programDataWord === 16'hc35a, "program data");
		algBusy <= 1'b1;
		repeat (2) @(posedge clk);
		check(busyStatusPin === 1'b0, "busy pin");
		host.rd(16'h0246, 20'h1, d);
		check(d[7] === 1'b1, "polling bit");
		check(d[5] === 1'b0, "error bit during program");
		t = d[6];
		host.rd(16'h0246, 20'h1, d);
		check(d[6] === ~t, "toggle bit");
		algBusy <= 1'b0;
		host.rd(16'h0246, 20'h1, d);
		check(d === 16'h581c, "read after program");
	endtask
	task automatic t_refuse();
		int n;
		for (int i = 0; i < 5; i++) begin
			n = progCnt;
			cw(i == 1 ? 16'h02aa : 16'h0aaa, CMD_UNLOCK1, 20'h1);
			cw(16'h0554, i == 0 ? 8'h56 : CMD_UNLOCK2, 20'h1);
			if (i == 4) repeat (40) @(posedge clk);
			cw(16'h0aaa, CMD_PROGRAM, 20'h1);
			writeLockoutVoltage <= (i == 3);
			host.wr(16'h0246, 16'h1234, i == 2 ? 20'h0 : 20'h1);
			writeLockoutVoltage <= 1'b0;
			repeat (40) @(posedge clk);
			check(progCnt == n, "refused program");
		end
	endtask
	task automatic t_sector();
		int n, p, s, r;
		n = eraseCnt;
		p = progCnt;
		s = suspCnt;
		r = resCnt;
		cw(16'h0000, CMD_SUSPEND, 20'h1);
		erase6(CMD_SECTOR, 16'h0100, 20'h2);
		cw(16'h0200, CMD_SECTOR, 20'h20);
		check(eraseCnt == n && suspCnt == s, "early erase or suspend");
		repeat (40) @(posedge clk);
		check(eraseCnt == n + 1 && eraseSectorMask === 20'h22, "sector erase");
		algBusy <= 1'b1;
		cw(16'h0000, CMD_SUSPEND, 20'h1);
		repeat (3) @(posedge clk);
		check(suspCnt == s + 1, "suspend");
		algBusy <= 1'b0;
		prog(16'h0010, 16'h00ff, 20'h1);
		prog(16'h0100, 16'h00ff, 20'h2);
		check(progCnt == p + 1, "program while suspended");
		cw(16'h0000, CMD_SECTOR, 20'h1);
		algBusy <= 1'b1;
		cw(16'h0000, CMD_SECTOR, 20'h1);
		repeat (3) @(posedge clk);
		check(resCnt == r + 1, "resume once");
		algBusy <= 1'b0;
	endtask
	task automatic t_bulk();
		logic [31:0] r;
		int n;
		n = bulkCnt;
		erase6(CMD_BULK, {4'h3, ADR_UNLOCK1}, 20'h1);
		repeat (3) @(posedge clk);
		check(bulkCnt == n + 1 && eraseStart === 1'b0, "bulk erase");
		algBusy <= 1'b1;
		algFail <= 1'b1;
		@(posedge clk);
		algFail <= 1'b0;
		algBusy <= 1'b0;
		bus(1'b0, REG_STATUS, 32'h0, r);
		check(r[1] === 1'b1, "error bit set");
		cw(16'h0000, CMD_RESET, 20'h1);
		bus(1'b0, REG_STATUS, 32'h0, r);
		check(r[1] === 1'b0, "error bit cleared");
	endtask
	task automatic t_ident();
		logic [15:0] d;
		unl(20'h1);
		cw({4'h0, ADR_UNLOCK1}, CMD_AUTOSEL, 20'h1);
		host.rd({8'h00, ADR_ID}, 20'h1, d);
		check(d[7:0] === ID_CODE, "identifier");
		host.rd({8'h00, ADR_PROT}, 20'h8, d);
		check(d[7:0] === 8'h01, "protected sector");
		host.rd({8'h00, ADR_PROT}, 20'h4, d);
		check(d[7:0] === 8'h00, "unprotected sector");
		cw(16'h0000, CMD_RESET, 20'h1);
		host.rd({8'h00, ADR_ID}, 20'h1, d);
		check(d === 16'h5a58, "read after reset command");
	endtask
	task automatic t_bypass();
		logic [15:0] d;
		int p;
		p = progCnt;
		unl(20'h10000);
		cw({4'h0, ADR_UNLOCK1}, CMD_BYPASS, 20'h10000);
		for (int i = 0; i < 2; i++) begin
			cw(16'h0126, CMD_PROGRAM, 20'h10000);
			host.wr(16'h0300 + 16'(2 * i), 16'h1357 + 16'(i), 20'h10000);
		end
		repeat (3) @(posedge clk);
		check(progCnt == p + 2 && programAddress === 16'h0302, "bypass programs");
		cw(16'h0040, CMD_AUTOSEL, 20'h10000);
		cw(16'h0040, CMD_BYPEXIT, 20'h10000);
		host.rd(16'h0300, 20'h10000, d);
		check(d === 16'h595a, "read after bypass exit");
		cw(16'h0126, CMD_PROGRAM, 20'h10000);
		host.wr(16'h0304, 16'h1111, 20'h10000);
		repeat (3) @(posedge clk);
		check(progCnt == p + 2, "no bypass after exit");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_program();
		t_refuse();
		t_sector();
		t_bulk();
		t_ident();
		t_bypass();
		report_and_stop();
	end
	initial begin
		#40000;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
